// ==== hdl/ssp_pkg.sv ====
package ssp_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h01;
  localparam logic [7:0] OFF_DATA = 8'h02;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;

  // ****************************************
  // field layouts
  // ****************************************
  typedef struct packed {
    logic       port_enable_bit;
    logic       controller_select;
    logic       clk_polarity;
    logic       clk_phase;
    logic       select_pin_disable;
    logic       low_bit_first;
    logic [1:0] clock_rate_select;
  } ssp_ctrl_t;

  typedef struct packed {
    logic       transfer_done_flag;
    logic       write_collision_flag;
    logic       mode_fault_flag;
    logic       rx_overrun_flag;
    logic       receive_full_flag;
    logic       transfer_busy_flag;
    logic [1:0] unused;
  } ssp_stat_t;

  localparam ssp_stat_t STAT_RESET = '{default: 1'b0};

  typedef struct packed {
    logic sck_o;
    logic sck_oe;
    logic mosi_o;
    logic mosi_oe;
    logic miso_o;
    logic miso_oe;
  } ssp_pin_t;

  localparam ssp_pin_t PIN_RESET = '{default: 1'b0};

  // ****************************************
  // timing and byte framing
  // ****************************************
  localparam int         BYTE_BITS     = 8;
  localparam logic [3:0] LAST_EDGE_IDX = 4'hf;
  localparam logic [2:0] LAST_BIT_IDX  = 3'h7;
  localparam logic [3:0] DIV_ONE       = 4'h1;

  typedef enum logic [1:0] {
    SSP_IDLE = 2'b01,
    SSP_RUN  = 2'b10
  } ssp_state_t;

endpackage : ssp_pkg

// ==== hdl/ssp_clk_gen.sv ====
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// half-period tick for the master clock
// ****************************************
module ssp_clk_gen (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  // control
  input  wire logic       run,
  input  wire logic [1:0] rate,
  // tick out
  output var  logic       tick
);

  logic [3:0] cnt_r;
  logic [3:0] lim;

  // half period of 1, 2, 4 or 8 clocks gives sck at clk/2 .. clk/16
  assign lim = 4'((ssp_pkg::DIV_ONE << rate) - ssp_pkg::DIV_ONE); // [R17] [R2]

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_r <= 4'h0;
      tick  <= 1'b0;
    end else if (ce) begin
      if (!run) begin
        cnt_r <= 4'h0;
        tick  <= 1'b0;
      end else if (cnt_r == lim) begin
        cnt_r <= 4'h0;
        tick  <= 1'b1;
      end else begin
        cnt_r <= 4'(cnt_r + 4'h1);
        tick  <= 1'b0;
      end
    end
  end

  chk_tick_spacing: assert property ( // [R17] [R2]
    @(posedge clk) disable iff (!rst_n)
    (ce && tick && run && rate != 2'h0) |=> !tick)
    else $error("tick came faster than the selected rate");

endmodule : ssp_clk_gen

`default_nettype wire

// ==== hdl/ssp_shifter.sv ====
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// eight-bit shift register, either end first
// ****************************************
module ssp_shifter (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  // control
  input  wire logic       load,
  input  wire logic [7:0] din,
  input  wire logic       shift,
  input  wire logic       sin,
  input  wire logic       lsb_first,
  // state
  output var  logic [7:0] data,
  output var  logic       head
);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      data <= ssp_pkg::DATA_RESET;
    end else if (ce) begin
      if (load) begin
        data <= din;
      end else if (shift) begin
        data <= lsb_first ? {sin, data[7:1]} : {data[6:0], sin}; // [R5] [R1]
      end
    end
  end

  assign head = lsb_first ? data[0] : data[7]; // [R5]

  chk_head_order: assert property ( // [R5]
    @(posedge clk) disable iff (!rst_n)
    (ce && load) |=> head == ($past(lsb_first) ? $past(din[0]) : $past(din[7])))
    else $error("first bit out does not follow the bit order");

endmodule : ssp_shifter

`default_nettype wire

// ==== hdl/ssp_port.sv ====
`timescale 1ns/1ps
`default_nettype none

// What this block does
// (R1) full duplex: shift out and in together
// (R2) serial clock at most system clock over two
// (R3) master drives sck, mosi; miso is input
// (R4) slave drives miso; sck, mosi are inputs
// (R5) bit order selects msb or lsb first
// (R6) selected-off slave ignores sck and mosi
// (R7) select-pin disable ignores ss entirely
// (R8) enabled-select slave shifts only while ss low
// (R9) master sees ss low: set mode fault
// (R10) controller select plus data write starts transfer
// (R11) idle write loads shifter, shifts both ways
// (R12) end: done flag, buffer copy, full flag
// (R13) software reads data before next byte ends
// (R14) busy from start to eighth period end; as slave, busy follows ss, or the enable when ss is ignored
// (R15) master selects one slave at a time
// (R16) multi-master buses keep ss enabled
// (R17) rate field divides by 2,4,8,16 master only
// (R18) polarity sets idle level, phase sample edge
// (R19) write while busy dropped, sets collision flag
// (R20) mode fault clears enable and controller select
// (R21) eight bits per transfer, one per period
module ssp_port (
  // clock, reset, enable
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              ce,
  // register port
  input  wire logic [7:0]        addr,
  input  wire logic [7:0]        wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output var  logic [7:0]        rdata,
  // serial pins
  input  wire logic              sck_i,
  input  wire logic              mosi_i,
  input  wire logic              miso_i,
  input  wire logic              ss_n,
  output var  ssp_pkg::ssp_pin_t pins
);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ****************************************
  // registers and mode decode
  // ****************************************
  ssp_pkg::ssp_ctrl_t  serial_control_reg;
  ssp_pkg::ssp_stat_t  serial_status_reg;
  ssp_pkg::ssp_state_t st_r;
  ssp_pkg::ssp_state_t st_nxt;
  logic [7:0]          rx_buf_r;
  logic [3:0]          edge_cnt_r;
  logic [2:0]          bit_cnt_r;
  logic                sck_r;
  logic                out_r;
  logic                sck_prev_r;
  logic                tick;
  logic                head;
  logic [7:0]          sr_data;

  logic master_on;
  logic slave_on;
  logic slave_act;
  logic fault;
  logic wr_data;
  logic wr_ctrl;
  logic wr_stat;
  logic rd_data;
  logic busy_w;
  logic start;
  logic collide;
  logic edge_ev;
  logic first_edge;
  logic sample_ev;
  logic shift_ev;
  logic done;
  logic wdata_head;
  logic sck_nxt;
  logic out_nxt;

  assign master_on = serial_control_reg.port_enable_bit && serial_control_reg.controller_select;
  assign slave_on  = serial_control_reg.port_enable_bit && !serial_control_reg.controller_select;
  assign slave_act = slave_on && (serial_control_reg.select_pin_disable || !ss_n); // [R6] [R7] [R8]
  assign fault     = master_on && !serial_control_reg.select_pin_disable && !ss_n; // [R9] [R7]

  assign wr_data = ce && wr && addr == ssp_pkg::OFF_DATA;
  assign wr_ctrl = ce && wr && addr == ssp_pkg::OFF_CTRL;
  assign wr_stat = ce && wr && addr == ssp_pkg::OFF_STAT;
  assign rd_data = ce && rd && addr == ssp_pkg::OFF_DATA;

  // slave busy follows ss, or the enable when ss is ignored
  assign busy_w  = master_on ? (st_r == ssp_pkg::SSP_RUN)
                 : slave_on && (serial_control_reg.select_pin_disable || !ss_n);
  assign start   = wr_data && !busy_w && (master_on || slave_on) && !fault; // [R10] [R11]
  assign collide = wr_data && busy_w; // [R19]

  assign wdata_head = serial_control_reg.low_bit_first ? wdata[0] : wdata[7];

  // ****************************************
  // edge events, master and slave
  // ****************************************
  // master edges come from the divider; slave edges from the sampled pin
  assign edge_ev    = master_on ? (tick && st_r == ssp_pkg::SSP_RUN)
                    : slave_act && (sck_i != sck_prev_r);
  assign first_edge = master_on ? !edge_cnt_r[0] : (sck_prev_r == serial_control_reg.clk_polarity);
  assign sample_ev  = edge_ev && (first_edge ^ serial_control_reg.clk_phase); // [R18]
  assign shift_ev   = edge_ev && !(first_edge ^ serial_control_reg.clk_phase); // [R18]
  assign done       = master_on ? (edge_ev && edge_cnt_r == ssp_pkg::LAST_EDGE_IDX) // [R14] [R21]
                    : (sample_ev && bit_cnt_r == ssp_pkg::LAST_BIT_IDX); // [R21]
  // pins take the next value so the pin edge and the miso sample share a clock
  assign sck_nxt    = (st_r != ssp_pkg::SSP_RUN) ? serial_control_reg.clk_polarity // [R18]
                    : (sck_r ^ edge_ev); // [R2]
  assign out_nxt    = start ? wdata_head : (shift_ev ? head : out_r); // [R11] [R1]

  ssp_clk_gen u_clk_gen (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .run   (st_r == ssp_pkg::SSP_RUN),
    .rate  (serial_control_reg.clock_rate_select), // [R17]
    .tick  (tick)
  );

  // in from miso as master, from mosi as slave
  ssp_shifter u_shifter (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .load  (start),
    .din   (wdata),
    .shift (sample_ev),
    .sin   (master_on ? miso_i : mosi_i), // [R1] [R3] [R4]
    .lsb_first (serial_control_reg.low_bit_first),
    .data  (sr_data),
    .head  (head)
  );

  // ****************************************
  // master sequencer
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      ssp_pkg::SSP_IDLE: begin
        if (start && master_on) begin
          st_nxt = ssp_pkg::SSP_RUN; // [R10] [R14]
        end
      end
      ssp_pkg::SSP_RUN: begin
        if (done || !master_on || fault) begin
          st_nxt = ssp_pkg::SSP_IDLE; // [R14] [R20]
        end
      end
      default: st_nxt = ssp_pkg::SSP_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r <= ssp_pkg::SSP_IDLE;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      edge_cnt_r <= 4'h0;
      sck_r      <= 1'b0;
    end else if (ce) begin
      sck_r <= sck_nxt; // [R18] [R2]
      if (st_r != ssp_pkg::SSP_RUN) begin
        edge_cnt_r <= 4'h0;
      end else if (edge_ev) begin
        edge_cnt_r <= 4'(edge_cnt_r + 4'h1);
      end
    end
  end

  // ****************************************
  // slave bit count and data out
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bit_cnt_r  <= 3'h0;
      sck_prev_r <= 1'b0;
    end else if (ce) begin
      sck_prev_r <= sck_i;
      if (!slave_act) begin
        bit_cnt_r <= 3'h0; // [R6] [R8]
      end else if (sample_ev) begin
        bit_cnt_r <= 3'(bit_cnt_r + 3'h1); // [R21]
      end
    end
  end

  // both phases show the first bit at load; phase 1 drives it again on the first edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      out_r <= 1'b0;
    end else if (ce) begin
      out_r <= out_nxt; // [R1] [R18]
    end
  end

  // ****************************************
  // control register
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      serial_control_reg <= ssp_pkg::CTRL_RESET;
    end else if (ce) begin
      if (wr_ctrl) begin
        serial_control_reg <= wdata;
      end
      if (fault) begin
        serial_control_reg.port_enable_bit   <= 1'b0; // [R20]
        serial_control_reg.controller_select <= 1'b0; // [R20]
      end
    end
  end

  // ****************************************
  // status flags: write 0 clears, hardware set wins
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      serial_status_reg <= ssp_pkg::STAT_RESET;
    end else if (ce) begin
      if (wr_stat) begin
        if (!wdata[7]) serial_status_reg.transfer_done_flag   <= 1'b0;
        if (!wdata[6]) serial_status_reg.write_collision_flag <= 1'b0;
        if (!wdata[5]) serial_status_reg.mode_fault_flag      <= 1'b0;
        if (!wdata[4]) serial_status_reg.rx_overrun_flag      <= 1'b0;
        if (!wdata[3]) serial_status_reg.receive_full_flag    <= 1'b0;
      end
      if (rd_data) begin
        serial_status_reg.receive_full_flag <= 1'b0;
        serial_status_reg.rx_overrun_flag   <= 1'b0;
      end
      if (start) begin
        serial_status_reg.write_collision_flag <= 1'b0;
      end
      if (collide) begin
        serial_status_reg.write_collision_flag <= 1'b1; // [R19]
      end
      if (fault) begin
        serial_status_reg.mode_fault_flag <= 1'b1; // [R9]
      end
      if (done) begin
        serial_status_reg.transfer_done_flag <= 1'b1; // [R12]
        serial_status_reg.receive_full_flag  <= 1'b1; // [R12]
        if (serial_status_reg.receive_full_flag) begin
          serial_status_reg.rx_overrun_flag <= 1'b1; // [R13]
        end
      end
      serial_status_reg.transfer_busy_flag <= master_on ? (st_nxt == ssp_pkg::SSP_RUN) : busy_w; // [R14]
    end
  end

  // slave keeps the older byte when the buffer is still full
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_buf_r <= ssp_pkg::DATA_RESET;
    end else if (ce && done && (master_on || !serial_status_reg.receive_full_flag)) begin
      // phase 0 master ends on a shift edge: the byte is already complete
      rx_buf_r <= sample_ev ? with_last_bit(sr_data) : sr_data; // [R12] [R21]
    end
  end

  function automatic logic [7:0] with_last_bit(input logic [7:0] d);
    with_last_bit = serial_control_reg.low_bit_first
                  ? {sample_in(), d[7:1]} : {d[6:0], sample_in()};
  endfunction : with_last_bit

  function automatic logic sample_in();
    sample_in = master_on ? miso_i : mosi_i;
  endfunction : sample_in

  // ****************************************
  // read port and pins
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (ce) begin
      rdata <= 8'h00;
      if (rd) begin
        unique case (addr)
          ssp_pkg::OFF_CTRL: rdata <= serial_control_reg;
          ssp_pkg::OFF_STAT: rdata <= serial_status_reg;
          ssp_pkg::OFF_DATA: rdata <= rx_buf_r;
          default:           rdata <= 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pins <= ssp_pkg::PIN_RESET;
    end else if (ce) begin
      pins.sck_o   <= master_on ? sck_nxt : serial_control_reg.clk_polarity; // [R18]
      pins.sck_oe  <= master_on; // [R3]
      pins.mosi_o  <= out_nxt; // [R11]
      pins.mosi_oe <= master_on; // [R3]
      pins.miso_o  <= out_nxt; // [R4]
      pins.miso_oe <= slave_act; // [R4] [R15]
    end
  end

  // ****************************************
  // checks
  // ****************************************
  sequence s_start;
    ce && start && master_on;
  endsequence

  chk_start_busy: assert property ( // [R10] [R14]
    s_start |=> serial_status_reg.transfer_busy_flag && st_r == ssp_pkg::SSP_RUN)
    else $error("start did not raise busy");

  chk_collide_flag: assert property ( // [R19]
    (collide && !start) |=> serial_status_reg.write_collision_flag && st_r == $past(st_r))
    else $error("collision not flagged");

  chk_collide_noload: assert property ( // [R19]
    (wr_data && busy_w) |-> !start)
    else $error("write during busy reached the shifter");

  chk_fault_clear: assert property ( // [R9] [R20]
    (ce && fault) |=> serial_status_reg.mode_fault_flag
      && !serial_control_reg.port_enable_bit && !serial_control_reg.controller_select)
    else $error("mode fault did not disable the port");

  chk_done_flags: assert property ( // [R12]
    (ce && done) |=> serial_status_reg.transfer_done_flag && serial_status_reg.receive_full_flag)
    else $error("end of transfer flags missing");

  chk_idle_level: assert property ( // [R18]
    (ce && st_r == ssp_pkg::SSP_IDLE) |=> sck_r == $past(serial_control_reg.clk_polarity))
    else $error("idle sck level wrong");

  chk_ss_ignored: assert property ( // [R6] [R8]
    (slave_on && !serial_control_reg.select_pin_disable && ss_n) |-> !edge_ev)
    else $error("deselected slave saw an edge");

  chk_master_pins: assert property ( // [R3] [R4]
    (ce && master_on) |=> pins.sck_oe && pins.mosi_oe && !pins.miso_oe)
    else $error("master pin directions wrong");

  chk_byte_end: assert property ( // [R14] [R21]
    (ce && master_on && st_r == ssp_pkg::SSP_RUN && done) |-> edge_cnt_r == ssp_pkg::LAST_EDGE_IDX
      ##1 (!serial_status_reg.transfer_busy_flag || !ce))
    else $error("transfer did not end after eight periods");

endmodule : ssp_port

`default_nettype wire

// ==== test/ssp_slave_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// far-side peripheral on the master pins
// ****************************************
module ssp_slave_model (
  // master pins and own select
  input  wire ssp_pkg::ssp_pin_t pins,
  input  wire logic              sel_n,
  // mode
  input  wire logic              cpol,
  input  wire logic              cpha,
  input  wire logic              lsb_first,
  input  wire logic [7:0]        tx,
  // answer
  output var  logic              miso,
  output var  logic [7:0]        rx,
  output var  int                n_edges
);
  int b;

  initial begin
    miso    = 1'b0;
    rx      = 8'h00;
    n_edges = 0;
    b       = 0;
  end

  // released line: inverse of last bit so a stale sample shows
  always @(posedge sel_n) miso = ~miso;

  always @(negedge sel_n) begin
    rx      = 8'h00;
    n_edges = 0;
    b       = cpha ? 0 : 1;
    if (!cpha) miso = tx[lsb_first ? 0 : 7];
  end

  // reacts to the pin at once, like a real part
  always @(pins.sck_o) begin
    if (!sel_n && pins.sck_oe) begin
      n_edges++;
      if ((pins.sck_o != cpol) ^ cpha) begin
        rx = lsb_first ? {pins.mosi_o, rx[7:1]} : {rx[6:0], pins.mosi_o};
      end else if (b < 8) begin
        miso = tx[lsb_first ? b : 7 - b];
        b++;
      end
    end
  end
endmodule : ssp_slave_model

`default_nettype wire

// ==== test/tb_ssp_port.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb_ssp_port;
  logic              clk, rst_n, ce, wr, rd, sck_i, mosi_i, ss_n;
  logic              sel_n, cpol, cpha, lsb_first, sck_q;
  logic [7:0]        addr, wdata, rdata, m_tx, m_rx, v, tx, c;
  ssp_pkg::ssp_pin_t pins;
  logic              miso;
  int                m_edges, seed, mismatches, n_tests, cyc, last, ne, gmin, gmax;

  ssp_port DUT (.clk(clk), .rst_n(rst_n), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .sck_i(sck_i), .mosi_i(mosi_i), .miso_i(miso), .ss_n(ss_n), .pins(pins));

  ssp_slave_model PEER (.pins(pins), .sel_n(sel_n), .cpol(cpol), .cpha(cpha), .lsb_first(lsb_first),
    .tx(m_tx), .miso(miso), .rx(m_rx), .n_edges(m_edges));

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [7:0] st(input logic dn, wc, mf, full, bsy);
    return {dn, wc, mf, 1'b0, full, bsy, 2'b00};
  endfunction : st

  task automatic chk(input string nm, input logic [7:0] s, e);
    n_tests++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %s exp %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask : rd_reg

  task automatic complete_run;
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run

  // one master byte; a second write lands while busy and must be dropped
  task automatic xfer(input logic [7:0] c, t, s);
    {cpol, cpha, lsb_first} = {c[5:4], c[2]};
    m_tx = s;
    wr_reg(ssp_pkg::OFF_CTRL, c);
    repeat (2) @(posedge clk);
    sel_n <= 1'b0; // one peripheral selected at a time
    ne   = 0;
    gmin = 99;
    gmax = 0;
    @(posedge clk);
    wr_reg(ssp_pkg::OFF_DATA, t);
    rd_reg(ssp_pkg::OFF_STAT, v); chk("busy", v, st(0, 0, 0, 0, 1));
    wr_reg(ssp_pkg::OFF_DATA, ~t);
    for (int k = 0; k < 400 && v[2] !== 1'b0; k++) rd_reg(ssp_pkg::OFF_STAT, v);
    chk("stat_end", v, st(1, 1, 0, 1, 0));
    chk("edges", 8'(m_edges), 8'h10);
    chk("mosi_byte", m_rx, t);
    chk("gap_min", 8'(gmin), 8'(1 << c[1:0]));
    chk("gap_max", 8'(gmax), 8'(1 << c[1:0]));
    chk("idle_lvl", {7'h00, pins.sck_o}, {7'h00, c[5]});
    chk("oe_master", {5'h00, pins.sck_oe, pins.mosi_oe, pins.miso_oe}, 8'h06);
    rd_reg(ssp_pkg::OFF_DATA, v); chk("miso_byte", v, s);
    rd_reg(ssp_pkg::OFF_STAT, v); chk("stat_rd", v, st(1, 1, 0, 0, 0));
    wr_reg(ssp_pkg::OFF_STAT, 8'h00);
    sel_n <= 1'b1;
  endtask : xfer

  // master-side byte into the slave, clk/8, first-edge sampling, msb first
  // so: what the slave shows on miso at each sample edge
  task automatic sbyte(input logic [7:0] b, output logic [7:0] so);
    for (int k = 7; k >= 0; k--) begin
      mosi_i <= b[k];
      repeat (4) @(posedge clk);
      so[k] = pins.miso_o;
      sck_i <= 1'b1;
      repeat (4) @(posedge clk);
      sck_i <= 1'b0;
    end
    repeat (4) @(posedge clk);
  endtask : sbyte

  // ****************************************
  // clock, monitor, watchdog, sequence
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // half-period spacing of the master clock pin
  always @(posedge clk) begin
    cyc++;
    if (pins.sck_o !== sck_q) begin
      if (ne > 0) begin
        gmin = (cyc - last < gmin) ? cyc - last : gmin;
        gmax = (cyc - last > gmax) ? cyc - last : gmax;
      end
      ne++;
      last = cyc;
    end
    sck_q = pins.sck_o;
  end

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    complete_run();
  end

  initial begin
    {rst_n, wr, rd, sck_i, mosi_i, cpol, cpha, lsb_first} = '0;
    {ce, ss_n, sel_n} = 3'b111;
    {addr, wdata, m_tx} = '0;
    {mismatches, n_tests, cyc, last, ne} = '0;
    seed = 28;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("pins_rst", {2'b00, pins}, {2'b00, ssp_pkg::PIN_RESET});
    rd_reg(ssp_pkg::OFF_CTRL, v); chk("ctrl_rst", v, ssp_pkg::CTRL_RESET);
    rd_reg(ssp_pkg::OFF_STAT, v); chk("stat_rst", v, ssp_pkg::STAT_RESET);
    rd_reg(ssp_pkg::OFF_DATA, v); chk("data_rst", v, ssp_pkg::DATA_RESET);
    wr_reg(8'h3c, 8'hff);
    rd_reg(8'h3c, v); chk("unmapped", v, 8'h00);
    // select pulled low in mid-transfer aborts and drops master mode
    wr_reg(ssp_pkg::OFF_CTRL, 8'hc3);
    wr_reg(ssp_pkg::OFF_DATA, 8'h5a);
    repeat (20) @(posedge clk);
    ss_n <= 1'b0; // a second master shows up on the select input
    repeat (3) @(posedge clk);
    rd_reg(ssp_pkg::OFF_CTRL, v); chk("ctrl_fault", v, 8'h03);
    rd_reg(ssp_pkg::OFF_STAT, v); chk("stat_fault", v, st(0, 0, 1, 0, 0));
    ss_n <= 1'b1;
    wr_reg(ssp_pkg::OFF_STAT, 8'h00);
    // every rate and clock type, select ignored while disabled
    for (int i = 0; i < 24; i++) begin
      c = {2'b11, 2'(i >> 2), 1'b1, 1'($random(seed)), 2'(i)};
      ss_n <= 1'($random(seed));
      tx = $random(seed);
      xfer(c, tx, 8'($random(seed)));
    end
    // slave: unselected traffic ignored, then one selected byte
    ss_n <= 1'b1;
    wr_reg(ssp_pkg::OFF_CTRL, 8'h80);
    sbyte(8'h3c, v);
    rd_reg(ssp_pkg::OFF_STAT, v); chk("stat_unsel", v, 8'h00);
    chk("oe_unsel", {7'h00, pins.miso_oe}, 8'h00);
    // idle slave takes its answer byte before it is selected
    c = 8'($random(seed));
    wr_reg(ssp_pkg::OFF_DATA, c);
    ss_n <= 1'b0;
    repeat (3) @(posedge clk);
    chk("oe_slave", {5'h00, pins.sck_oe, pins.mosi_oe, pins.miso_oe}, 8'h01);
    tx = $random(seed);
    sbyte(tx, v);
    chk("slave_tx", v, c);
    ss_n <= 1'b1;
    repeat (2) @(posedge clk);
    rd_reg(ssp_pkg::OFF_STAT, v); chk("stat_slave", v, st(1, 0, 0, 1, 0));
    rd_reg(ssp_pkg::OFF_DATA, v); chk("slave_rx", v, tx);
    complete_run();
  end
endmodule : tb_ssp_port

`default_nettype wire
